// [logic/input_select_pkg.sv]
package input_select_pkg;

  // Register word and selector field geometry
  localparam int unsigned DATA_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned SEL_W  = 7;
  localparam int unsigned PIN_W  = 128;

  // Register offsets (word index on the register port)
  localparam logic [3:0] OFS_UART1_RX  = 4'h0;
  localparam logic [3:0] OFS_UART2_RX  = 4'h1;
  localparam logic [3:0] OFS_SPI2_CKDI = 4'h2;
  localparam logic [3:0] OFS_SPI2_SS   = 4'h3;
  localparam logic [3:0] OFS_CAN_RX    = 4'h4;
  localparam logic [3:0] OFS_PWM_SYNC  = 4'h5;

  // Field positions
  localparam int unsigned FIELD_LO_POS = 0;
  localparam int unsigned FIELD_HI_POS = 8;

  // Writable masks per register
  localparam logic [15:0] MASK_LO   = 16'h007F;
  localparam logic [15:0] MASK_BOTH = 16'h7F7F;
  localparam logic [15:0] MASK_HI   = 16'h7F00;
  localparam logic [15:0] RESET_VAL = 16'h0000;

  // Defined selector codes
  localparam logic [6:0] CODE_GROUND     = 7'h00;
  localparam logic [6:0] CODE_COMPARATOR = 7'h01;
  localparam logic [6:0] CODE_PIN_121    = 7'h79;

  // Register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Selector fields gathered for the routing stage
  typedef struct packed {
    logic [6:0] uart1_rx;
    logic [6:0] uart2_rx;
    logic [6:0] spi2_clk;
    logic [6:0] spi2_din;
    logic [6:0] spi2_ss;
    logic [6:0] can_rx;
    logic [6:0] pwm_sync;
  } sel_fields_t;

  // Routed peripheral inputs
  typedef struct packed {
    logic first_uart_receive_input;
    logic second_uart_receive_input;
    logic second_spi_clock;
    logic second_spi_data_in;
    logic second_spi_slave_select;
    logic can_receive_input;
    logic pwm_sync_in;
  } periph_in_t;

endpackage

// [logic/remappable_input_selector.sv]
// Our own choices: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Functional notes
// RULE1: code 121 selects remappable input pin 121
// RULE2: code one selects comparator one output
// RULE3: code zero ties input to ground
// RULE4: unfielded bits ignore writes, read zero
// RULE5: selector bits read/write, reset to zero
// RULE6: first uart receive field bits 6-0
// RULE7: second uart receive field bits 6-0
// RULE8: spi2 clock field bits 14-8
// RULE9: spi2 data-in field bits 6-0
// RULE10: spi2 slave select field bits 6-0
// RULE11: can receive field bits 6-0
// RULE12: pwm sync field bits 14-8
// RULE13: other codes pick pins via table
module remappable_input_selector #(
  parameter logic [127:0] PIN_PRESENT = {128{1'b1}},
  parameter bit           HAS_CAN     = 1'b1,
  parameter bit           HAS_MOTOR   = 1'b1
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // Register port
  input  wire logic [3:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output logic      [15:0] reg_rdata_out,
  // Sources
  input  wire logic [127:0] remappable_pin_n_in,
  input  wire logic         comparator_one_output_in,
  // Routed peripheral inputs
  output input_select_pkg::periph_in_t periph_out
);

  input_select_pkg::reg_req_t  req;
  input_select_pkg::sel_fields_t fields;
  logic [15:0] val_u1;
  logic [15:0] val_u2;
  logic [15:0] val_sp;
  logic [15:0] val_ss;
  logic [15:0] val_can;
  logic [15:0] val_pwm;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] rd_sel;

  assign req = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

  // Address decode for writes
  wire hit_u1  = (req.addr == input_select_pkg::OFS_UART1_RX);
  wire hit_u2  = (req.addr == input_select_pkg::OFS_UART2_RX);
  wire hit_sp  = (req.addr == input_select_pkg::OFS_SPI2_CKDI);
  wire hit_ss  = (req.addr == input_select_pkg::OFS_SPI2_SS);
  wire hit_can = (req.addr == input_select_pkg::OFS_CAN_RX) && HAS_CAN;
  wire hit_pwm = (req.addr == input_select_pkg::OFS_PWM_SYNC) && HAS_MOTOR;

  // Selector registers, each with its own writable mask
  select_reg #(
    .MASK      (input_select_pkg::MASK_LO)
  ) u_uart1 ( // RULE6
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wr_in     (req.wr && hit_u1),
    .wdata_in  (req.wdata),
    .value_out (val_u1)
  );

  select_reg #(
    .MASK      (input_select_pkg::MASK_LO)
  ) u_uart2 ( // RULE7
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wr_in     (req.wr && hit_u2),
    .wdata_in  (req.wdata),
    .value_out (val_u2)
  );

  // Clock and data share one word, so both fields are writable
  select_reg #(
    .MASK      (input_select_pkg::MASK_BOTH)
  ) u_spi2 ( // RULE8 RULE9
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wr_in     (req.wr && hit_sp),
    .wdata_in  (req.wdata),
    .value_out (val_sp)
  );

  select_reg #(
    .MASK      (input_select_pkg::MASK_LO)
  ) u_slave_sel ( // RULE10
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wr_in     (req.wr && hit_ss),
    .wdata_in  (req.wdata),
    .value_out (val_ss)
  );

  // Absent on variants without the bus controller: hit never rises
  select_reg #(
    .MASK      (input_select_pkg::MASK_LO)
  ) u_can ( // RULE11
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wr_in     (req.wr && hit_can),
    .wdata_in  (req.wdata),
    .value_out (val_can)
  );

  // Field sits in the upper byte; lower byte stays zero
  select_reg #(
    .MASK      (input_select_pkg::MASK_HI)
  ) u_pwm ( // RULE12
    .mclk_in   (mclk_in),
    .resetn_in (resetn_in),
    .wr_in     (req.wr && hit_pwm),
    .wdata_in  (req.wdata),
    .value_out (val_pwm)
  );

  // Field extraction
  assign fields.uart1_rx = val_u1[input_select_pkg::FIELD_LO_POS +: 7];  // RULE6
  assign fields.uart2_rx = val_u2[input_select_pkg::FIELD_LO_POS +: 7];  // RULE7
  assign fields.spi2_clk = val_sp[input_select_pkg::FIELD_HI_POS +: 7];  // RULE8
  assign fields.spi2_din = val_sp[input_select_pkg::FIELD_LO_POS +: 7];  // RULE9
  assign fields.spi2_ss  = val_ss[input_select_pkg::FIELD_LO_POS +: 7];  // RULE10
  assign fields.can_rx   = val_can[input_select_pkg::FIELD_LO_POS +: 7]; // RULE11
  assign fields.pwm_sync = val_pwm[input_select_pkg::FIELD_HI_POS +: 7]; // RULE12

  // Read select; unmapped or absent registers read zero
  assign rd_sel = hit_u1  ? val_u1 :
                  hit_u2  ? val_u2 :
                  hit_sp  ? val_sp :
                  hit_ss  ? val_ss :
                  hit_can ? val_can :
                  hit_pwm ? val_pwm : 16'h0000; // RULE4
  assign rdata_next = req.rd ? rd_sel : 16'h0000;

  // Read data valid only in the cycle after the strobe
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      rdata_reg <= input_select_pkg::RESET_VAL;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata_out = rdata_reg;

  // Routed levels, gathered into the output struct in one place
  logic route_u1;
  logic route_u2;
  logic route_ck;
  logic route_di;
  logic route_ss;
  logic route_cn;
  logic route_pw;

  // Routing stages, combinational so pin edges pass with no added latency
  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_u1 (
    .code_in                  (fields.uart1_rx),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_u1)
  );

  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_u2 (
    .code_in                  (fields.uart2_rx),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_u2)
  );

  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_ck (
    .code_in                  (fields.spi2_clk),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_ck)
  );

  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_di (
    .code_in                  (fields.spi2_din),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_di)
  );

  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_ss (
    .code_in                  (fields.spi2_ss),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_ss)
  );

  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_cn (
    .code_in                  (fields.can_rx),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_cn)
  );

  source_mux #(
    .PIN_PRESENT              (PIN_PRESENT)
  ) m_pw (
    .code_in                  (fields.pwm_sync),
    .pins_in                  (remappable_pin_n_in),
    .comparator_one_output_in (comparator_one_output_in),
    .routed_out               (route_pw)
  );

  // One driver for the whole struct, not one per member
  assign periph_out = '{
    first_uart_receive_input:  route_u1,
    second_uart_receive_input: route_u2,
    second_spi_clock:          route_ck,
    second_spi_data_in:        route_di,
    second_spi_slave_select:   route_ss,
    can_receive_input:         route_cn,
    pwm_sync_in:               route_pw
  };

endmodule

// [logic/select_reg.sv]
`timescale 1ns/1ps
// One selector register with a fixed writable mask
module select_reg #(
  parameter logic [15:0] MASK = 16'h007F
) (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        resetn_in,
  // Write port
  input  wire logic        wr_in,
  input  wire logic [15:0] wdata_in,
  // Stored value
  output logic      [15:0] value_out
);

  logic [15:0] value_reg;
  logic [15:0] value_next;

  // Unfielded bits never take a write
  assign value_next = wr_in ? (wdata_in & MASK) : value_reg; // RULE4

  // Clears at reset so every input starts grounded
  always_ff @(posedge mclk_in) begin
    if (!resetn_in) begin
      value_reg <= input_select_pkg::RESET_VAL; // RULE5
    end else begin
      value_reg <= value_next;
    end
  end

  assign value_out = value_reg;

endmodule

// [logic/source_mux.sv]
`timescale 1ns/1ps
// Routes one peripheral input from its selected source
module source_mux #(
  parameter logic [127:0] PIN_PRESENT = {128{1'b1}}
) (
  // Selection
  input  wire logic [6:0]   code_in,
  // Sources
  input  wire logic [127:0] pins_in,
  input  wire logic         comparator_one_output_in,
  // Routed input
  output logic              routed_out
);

  wire is_ground = (code_in == input_select_pkg::CODE_GROUND);
  wire is_comp   = (code_in == input_select_pkg::CODE_COMPARATOR);
  wire is_top    = (code_in == input_select_pkg::CODE_PIN_121);
  // Codes beyond 121 are undefined and read as ground
  wire in_range  = (code_in < input_select_pkg::CODE_PIN_121);
  wire pin_bit   = pins_in[code_in] & PIN_PRESENT[code_in];

  // Priority: ground, comparator, top pin, table pins
  assign routed_out = is_ground ? 1'b0 :                          // RULE3
                      is_comp   ? comparator_one_output_in :      // RULE2
                      is_top    ? pins_in[121] :                  // RULE1
                      in_range  ? pin_bit : 1'b0;                 // RULE13

endmodule

// [verification/pin_driver.sv]
`timescale 1ns/1ps
// Pads and comparator that feed the remapping matrix
module pin_driver (
  // Levels asked for by the bench
  input  wire logic [127:0] level_in,
  input  wire logic         comp_in,
  // Levels seen by the selector
  output logic      [127:0] pins_out,
  output logic              comp_out
);
  // Inputs only, so each pad simply shows its present level
  assign pins_out = level_in;
  assign comp_out = comp_in;
endmodule

// [verification/remappable_input_selector_monitor.sv]
`timescale 1ns/1ps
module remappable_input_selector_monitor #(
  parameter logic [127:0] PIN_PRESENT = {128{1'b1}}
) (
  // Every port of the selector
  input wire logic                         mclk_in,
  input wire logic                         resetn_in,
  input wire logic [3:0]                   reg_addr_in,
  input wire logic [15:0]                  reg_wdata_in,
  input wire logic                         reg_wr_in,
  input wire logic                         reg_rd_in,
  input wire logic [15:0]                  reg_rdata_out,
  input wire logic [127:0]                 remappable_pin_n_in,
  input wire logic                         comparator_one_output_in,
  input wire input_select_pkg::periph_in_t periph_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  // Copy of the first receive field, so routing can be judged from ports
  logic [6:0] u1_code_reg;
  always_ff @(posedge mclk_in) begin
    if (!resetn_in)
      u1_code_reg <= 7'h00;
    else if (reg_wr_in && reg_addr_in == 4'h0)
      u1_code_reg <= reg_wdata_in[6:0];
  end
  wire u1_w = periph_out.first_uart_receive_input;
  // Write then read at once: read data is the masked write data
  property rw_p(logic [3:0] a, logic [15:0] m);
    reg_wr_in && reg_addr_in == a ##1 reg_rd_in && reg_addr_in == a
      |=> reg_rdata_out == ($past(reg_wdata_in, 2) & m);
  endproperty
  uart1_rw_a: assert property (rw_p(4'h0, 16'h007F)) else $error("uart1 readback");
  uart2_rw_a: assert property (rw_p(4'h1, 16'h007F)) else $error("uart2 readback");
  spi_rw_a: assert property (rw_p(4'h2, 16'h7F7F)) else $error("spi readback");
  ss_rw_a: assert property (rw_p(4'h3, 16'h007F)) else $error("ss readback");
  can_rw_a: assert property (rw_p(4'h4, 16'h007F)) else $error("can readback");
  pwm_rw_a: assert property (rw_p(4'h5, 16'h7F00)) else $error("pwm readback");
  idle_read_zero_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 16'h0000)
    else $error("read data outside read slot");
  reset_clear_a: assert property ($rose(resetn_in) |-> periph_out == 7'h00)
    else $error("outputs not cleared by reset");
  ground_route_a: assert property (u1_code_reg == 7'h00 |-> !u1_w)
    else $error("code zero not grounded");
  comp_route_a: assert property (u1_code_reg == 7'h01 |->
    u1_w == comparator_one_output_in)
    else $error("comparator not routed");
  pin121_route_a: assert property (u1_code_reg == 7'h79 |->
    u1_w == remappable_pin_n_in[121])
    else $error("pin 121 not routed");
  pin_table_a: assert property (u1_code_reg inside {[7'h02:7'h78]} |->
    u1_w == (remappable_pin_n_in[u1_code_reg] & PIN_PRESENT[u1_code_reg]))
    else $error("table pin not routed");
  cover property (reg_wr_in ##1 reg_rd_in);
  cover property (u1_code_reg == 7'h79);
  cover property ($rose(resetn_in));
endmodule
bind remappable_input_selector remappable_input_selector_monitor #(.PIN_PRESENT(PIN_PRESENT)) u_mon (
  .mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(reg_addr_in),
  .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_rdata_out(reg_rdata_out), .remappable_pin_n_in(remappable_pin_n_in),
  .comparator_one_output_in(comparator_one_output_in), .periph_out(periph_out));

// [verification/remappable_input_selector_tb.sv]
`timescale 1ns/1ps
module remappable_input_selector_tb;
  logic                         mclk_in = 1'b0;
  logic                         resetn_in = 1'b0;
  logic [3:0]                   addr = 4'h0;
  logic [15:0]                  wdata = 16'h0000;
  logic                         wr = 1'b0;
  logic                         rd = 1'b0;
  logic [127:0]                 level = '0;
  logic                         comp = 1'b0;
  logic [15:0]                  rdata;
  logic [127:0]                 pins;
  logic                         cmp_w;
  input_select_pkg::periph_in_t periph;
  int                           failures = 0;
  int                           n_tests = 0;
  logic [15:0]                  mask [6] = '{16'h007F, 16'h007F, 16'h7F7F, 16'h007F, 16'h007F,
                                             16'h7F00};
  always #25 mclk_in = ~mclk_in;
  pin_driver u_pins (.level_in(level), .comp_in(comp), .pins_out(pins), .comp_out(cmp_w));
  remappable_input_selector u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
    .remappable_pin_n_in(pins), .comparator_one_output_in(cmp_w), .periph_out(periph));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Bus cycles start just after a rising edge
  task wr_op(input logic [3:0] a, input logic [15:0] d);
    wr <= 1'b1;
    rd <= 1'b0;
    addr <= a;
    wdata <= d;
    @(posedge mclk_in);
  endtask
  task rd_chk(input logic [3:0] a, input logic [15:0] exp);
    rd <= 1'b1;
    wr <= 1'b0;
    addr <= a;
    @(posedge mclk_in);
    rd <= 1'b0;
    @(negedge mclk_in);
    check(rdata, exp);
    @(posedge mclk_in);
  endtask
  // Write a selector, then look at the routed inputs once settled
  task see(input logic [3:0] a, input logic [15:0] d, input logic [6:0] e);
    wr_op(a, d);
    wr <= 1'b0;
    @(negedge mclk_in);
    check({9'h000, periph}, {9'h000, e});
    @(posedge mclk_in);
  endtask
  task t_reset();
    for (int i = 0; i < 6; i++) begin
      rd_chk(i[3:0], 16'h0000);
    end
  endtask
  task t_rw();
    for (int i = 0; i < 6; i++) begin
      wr_op(i[3:0], 16'hFFFF);
      rd_chk(i[3:0], mask[i]);
    end
    wr_op(4'h6, 16'hFFFF);
    rd_chk(4'h6, 16'h0000);
  endtask
  // Pins 121, 37 and 127 high; 127 lies past the last code and must stay unrouted
  task t_route();
    level <= (128'h1 << 121) | (128'h1 << 37) | (128'h1 << 127);
    comp <= 1'b1;
    see(4'h0, 16'h0000, 7'h00);
    see(4'h0, 16'h0001, 7'h40);
    comp <= 1'b0;
    see(4'h0, 16'h0001, 7'h00);
    see(4'h0, 16'h0079, 7'h40);
    see(4'h0, 16'h0026, 7'h00);
    see(4'h0, 16'h0025, 7'h40);
    comp <= 1'b1;
    see(4'h1, 16'h0025, 7'h60);
    see(4'h2, 16'h0179, 7'h78);
    see(4'h3, 16'h0001, 7'h7C);
    see(4'h4, 16'h0079, 7'h7E);
    see(4'h5, 16'h7900, 7'h7F);
    see(4'h4, 16'h007F, 7'h7D);
    rd_chk(4'h2, 16'h0179);
  endtask
  // Reset in mid-run must return every input to ground
  task t_rereset();
    resetn_in <= 1'b0;
    repeat (2) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(negedge mclk_in);
    check({9'h000, periph}, 16'h0000);
    @(posedge mclk_in);
    rd_chk(4'h5, 16'h0000);
  endtask
  task end_sim();
    $display("Comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge mclk_in);
    resetn_in <= 1'b1;
    @(posedge mclk_in);
    t_reset();
    t_rw();
    t_route();
    t_rereset();
    end_sim();
  end
endmodule
